// >>> rtl/timer_b_pkg.sv
// Constants for the second 16-bit timer unit: register map, field layout, reset values.
// Assumes an 8-bit register port with byte addresses; shared by the core and the bench.
package timer_b_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] STATUS_CONTROL_ADDR = 8'h40;
  localparam logic [7:0] COUNTER_HIGH_ADDR = 8'h41;
  localparam logic [7:0] COUNTER_LOW_ADDR = 8'h42;
  localparam logic [7:0] MODULO_HIGH_ADDR = 8'h43;
  localparam logic [7:0] MODULO_LOW_ADDR = 8'h44;
  localparam logic [7:0] CH0_CONTROL_ADDR = 8'h45;
  localparam logic [7:0] CH_STRIDE = 8'h03;
  localparam logic [7:0] CH_HIGH_OFS = 8'h01;
  localparam logic [7:0] CH_LOW_OFS = 8'h02;

  // ==========================================================
  // Status and control fields
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_IRQ_EN_BIT = 6;
  localparam int SC_STOP_BIT = 5;
  localparam int SC_RESET_BIT = 4;
  localparam int SC_PS_LSB = 0;
  localparam int PS_WIDTH = 3;

  // ==========================================================
  // Channel control fields
  localparam int CH_FLAG_BIT = 7;
  localparam int CH_IRQ_EN_BIT = 6;
  localparam int CH_BUF_BIT = 5;
  localparam int CH_UNBUF_BIT = 4;
  localparam int CH_ELS_LSB = 2;
  localparam int CH_TOV_BIT = 1;
  localparam int CH_MAX_BIT = 0;

  // ==========================================================
  // Encodings and reset values
  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam int PRESCALE_WIDTH = 6;
  localparam logic [1:0] ELS_PORT = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'hFFFF;
  localparam logic STOP_RESET = 1'b1;

endpackage

// >>> rtl/timer_b_counter_pwm_core.sv
// Timer unit core: prescaled 16-bit modulo counter, two capture/compare/PWM channels.
// Assumes a synchronous 8-bit register port and pin inputs synchronous to clk_i.
//
// What this block does
// - Channel 0 buffered select links both channels; it overrides unbuffered select.
// - Without toggle-on-overflow or full-duty force, nothing sets the level after a compare clear: 0% duty.
// - Full-duty force with toggle-on-overflow clear holds 100% duty level.
// - Overflow sets flag on rollover; interrupt only while enable set.
// - Capture or compare sets channel flag; interrupt only when enabled.
// - Wait mode keeps counting, blocks register access, interrupts wake.
// - Break halts the counter.
// - Break clear enable decides whether flags may be cleared during break.
// - First clear step before break; second step during break ignored unless enabled.
// - Select 111 counts the external pin and forces it to input.
// - Channels configure independently unless channel 0 buffered select links them; channel 0 captures gated CAN frame pulse.
// - Overflow flag clears by read-with-flag then write zero; events cancel.
// - Stop holds the counter; reset sets stop.
// - Counter reset bit clears counter and prescaler only, self-clearing.
// - Stop and counter reset together leave counter stopped at zero.
// - Select 000..110 divides bus clock by 1 to 64.
// - High byte read latches low byte until low byte read.
// - Low byte latch taken in break survives until low byte read.
// - Counter at modulo sets flag and restarts at zero next tick.
// - Modulo high write suppresses overflow flag until low written.
// - Toggle-on-overflow toggles pin; overflow beats simultaneous compare.
// - Full-duty force change takes effect from the next PWM period.
// - Compare high byte write blocks compares until low byte write.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps

module timer_b_counter_pwm_core import timer_b_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic wait_mode_i,
  input wire logic break_i,
  input wire logic break_clear_enable_i,
  input wire logic ext_count_clock_pin_i,
  output logic ext_count_clock_input_o,
  input wire logic channel0_pin_i,
  input wire logic channel1_pin_i,
  input wire logic can_frame_capture_pulse_i,
  input wire logic capture_link_enable_i,
  output logic channel0_pin_o,
  output logic channel0_pin_oe_o,
  output logic channel1_pin_o,
  output logic channel1_pin_oe_o,
  output logic overflow_irq_o,
  output logic channel0_irq_o,
  output logic channel1_irq_o,
  output logic wakeup_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] cnt;
    logic [PRESCALE_WIDTH-1:0] pre;
    logic overflow_flag;
    logic tof_armed;
    logic overflow_irq_enable;
    logic stop;
    logic [2:0] ps;
    logic [15:0] modv;
    logic mod_pend;
    logic [7:0] low_latch;
    logic latched;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic msb0;
    logic buf_sel;
    logic buf_next;
    logic [1:0] chf;
    logic [1:0] chf_armed;
    logic [1:0] chie;
    logic [1:0] msa;
    logic [1:0] tov;
    logic [1:0] maxd;
    logic [1:0] maxd_eff;
    logic [1:0] hold;
    logic [1:0] pin_prev;
    logic [1:0] pin_level;
    logic [1:0] pin_oe;
    logic [1:0][1:0] els;
    logic [1:0][15:0] chv;
    logic [7:0] rdata;
    logic ovf_irq;
    logic [1:0] ch_irq;
    logic wake;
    logic ext_in;
  } state_t;

  state_t q;
  state_t next_q;
  logic acc_wr;
  logic acc_rd;
  logic flag_ok;
  logic run;
  logic tick;
  logic ovf;
  logic cnt_rst;
  logic ext_edge;
  logic [1:0] pin_in;
  logic [1:0] cmp_ev;

  // ==========================================================
  // Helpers
  function automatic logic prescale_tick(input logic [PRESCALE_WIDTH-1:0] pre, input logic [2:0] ps);
    logic [PRESCALE_WIDTH:0] full;
    full = (7'h01 << ps) - 7'h01;
    return (pre & full[PRESCALE_WIDTH-1:0]) == full[PRESCALE_WIDTH-1:0];
  endfunction

  function automatic logic [7:0] chan_addr(input int idx, input logic [7:0] ofs);
    logic [7:0] step;
    step = (idx == 0) ? 8'h00 : CH_STRIDE;
    return CH0_CONTROL_ADDR + step + ofs;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic outmode;
    logic active;
    logic [15:0] cmp_val;
    logic hold_now;
    logic cap_ev;
    logic cmp;
    logic rise;
    logic fall;
    outmode = 1'b0;
    active = 1'b0;
    cmp_val = COUNT_ZERO;
    hold_now = 1'b0;
    cap_ev = 1'b0;
    cmp = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    next_q = q;
    pin_in = {channel1_pin_i, channel0_pin_i};
    cmp_ev = 2'h0;
    acc_wr = wr_i && !wait_mode_i;
    acc_rd = rd_i && !wait_mode_i;
    flag_ok = !break_i || break_clear_enable_i;
    next_q.rdata = 8'h00;

    // External clock: two-stage synchroniser, edge taken after it
    next_q.ext_meta = ext_count_clock_pin_i;
    next_q.ext_sync = q.ext_meta;
    next_q.ext_prev = q.ext_sync;
    ext_edge = q.ext_sync && !q.ext_prev;

    // Counter control register and counter/modulo bytes
    cnt_rst = acc_wr && addr_i == STATUS_CONTROL_ADDR && wdata_i[SC_RESET_BIT];
    if (acc_rd) begin
      unique case (addr_i)
        STATUS_CONTROL_ADDR: begin
          next_q.rdata = {q.overflow_flag, q.overflow_irq_enable, q.stop, 2'b00, q.ps};
          if (q.overflow_flag && flag_ok) begin
            next_q.tof_armed = 1'b1;
          end
        end
        COUNTER_HIGH_ADDR: begin
          next_q.rdata = q.cnt[15:8];
          if (!q.latched) begin
            next_q.low_latch = q.cnt[7:0];
            next_q.latched = 1'b1;
          end
        end
        COUNTER_LOW_ADDR: begin
          next_q.rdata = q.latched ? q.low_latch : q.cnt[7:0];
          next_q.latched = 1'b0;
        end
        MODULO_HIGH_ADDR: next_q.rdata = q.modv[15:8];
        MODULO_LOW_ADDR: next_q.rdata = q.modv[7:0];
        default: next_q.rdata = 8'h00;
      endcase
    end
    if (acc_wr) begin
      unique case (addr_i)
        STATUS_CONTROL_ADDR: begin
          next_q.overflow_irq_enable = wdata_i[SC_IRQ_EN_BIT];
          next_q.stop = wdata_i[SC_STOP_BIT];
          next_q.ps = wdata_i[SC_PS_LSB +: PS_WIDTH];
          if (!wdata_i[SC_FLAG_BIT] && q.tof_armed && flag_ok) begin
            next_q.overflow_flag = 1'b0;
            next_q.tof_armed = 1'b0;
          end
        end
        MODULO_HIGH_ADDR: begin
          next_q.modv[15:8] = wdata_i;
          next_q.mod_pend = 1'b1;
        end
        MODULO_LOW_ADDR: begin
          next_q.modv[7:0] = wdata_i;
          next_q.mod_pend = 1'b0;
        end
        default: next_q.mod_pend = q.mod_pend;
      endcase
    end

    // Prescaler and counter
    run = !q.stop && !break_i;
    tick = run && ((q.ps == PS_EXTERNAL) ? ext_edge : prescale_tick(q.pre, q.ps));
    ovf = tick && !cnt_rst && q.cnt == q.modv;
    if (cnt_rst) begin
      next_q.cnt = COUNT_ZERO;
      next_q.pre = '0;
    end else begin
      if (run) begin
        next_q.pre = q.pre + PRESCALE_WIDTH'(1);
      end
      if (tick) begin
        next_q.cnt = ovf ? COUNT_ZERO : q.cnt + 16'h0001;
      end
    end
    if (ovf && !q.mod_pend) begin
      next_q.overflow_flag = 1'b1;
      next_q.tof_armed = 1'b0;
    end
    if (ovf) begin
      next_q.buf_sel = q.buf_next;
      next_q.maxd_eff = q.maxd;
    end

    // Channels
    for (int i = 0; i < 2; i++) begin
      if (acc_rd) begin
        if (addr_i == chan_addr(i, 8'h00)) begin
          next_q.rdata = {q.chf[i], q.chie[i], (i == 0) ? q.msb0 : 1'b0, q.msa[i], q.els[i], q.tov[i], q.maxd[i]};
          if (q.chf[i] && flag_ok) begin
            next_q.chf_armed[i] = 1'b1;
          end
        end
        if (addr_i == chan_addr(i, CH_HIGH_OFS)) begin
          next_q.rdata = q.chv[i][15:8];
          if (!q.msa[i] && !(i == 0 && q.msb0)) begin
            next_q.hold[i] = 1'b1;
          end
        end
        if (addr_i == chan_addr(i, CH_LOW_OFS)) begin
          next_q.rdata = q.chv[i][7:0];
          if (!q.msa[i] && !(i == 0 && q.msb0)) begin
            next_q.hold[i] = 1'b0;
          end
        end
      end
      if (acc_wr) begin
        if (addr_i == chan_addr(i, 8'h00)) begin
          next_q.chie[i] = wdata_i[CH_IRQ_EN_BIT];
          next_q.msa[i] = wdata_i[CH_UNBUF_BIT];
          next_q.els[i] = wdata_i[CH_ELS_LSB +: 2];
          next_q.tov[i] = wdata_i[CH_TOV_BIT];
          next_q.maxd[i] = wdata_i[CH_MAX_BIT];
          if (i == 0) begin
            next_q.msb0 = wdata_i[CH_BUF_BIT];
          end
          if (!wdata_i[CH_FLAG_BIT] && q.chf_armed[i] && flag_ok) begin
            next_q.chf[i] = 1'b0;
            next_q.chf_armed[i] = 1'b0;
          end
        end
        if (addr_i == chan_addr(i, CH_HIGH_OFS)) begin
          next_q.chv[i][15:8] = wdata_i;
          if (q.msa[i] || q.msb0) begin
            next_q.hold[i] = 1'b1;
          end
        end
        if (addr_i == chan_addr(i, CH_LOW_OFS)) begin
          next_q.chv[i][7:0] = wdata_i;
          next_q.hold[i] = 1'b0;
          next_q.buf_next = (i == 1);
        end
      end

      // Mode decode; buffered select takes priority over unbuffered select
      active = (i == 0) || !q.msb0;
      outmode = (i == 0 && q.msb0) || q.msa[i];
      cmp_val = (i == 0 && q.msb0) ? q.chv[q.buf_sel] : q.chv[i];
      hold_now = (i == 0 && q.msb0) ? q.hold[q.buf_sel] : q.hold[i];
      next_q.pin_prev[i] = pin_in[i];
      rise = pin_in[i] && !q.pin_prev[i];
      fall = !pin_in[i] && q.pin_prev[i];
      cap_ev = 1'b0;
      cmp = 1'b0;

      if (!active || q.els[i] == ELS_PORT) begin
        next_q.pin_oe[i] = 1'b0;
        next_q.pin_level[i] = !q.msa[i];
      end else if (!outmode) begin
        next_q.pin_oe[i] = 1'b0;
        unique case (q.els[i])
          ELS_TOGGLE: cap_ev = rise;
          ELS_CLEAR: cap_ev = fall;
          ELS_SET: cap_ev = rise || fall;
          default: cap_ev = 1'b0;
        endcase
        if (i == 0 && can_frame_capture_pulse_i && capture_link_enable_i) begin
          cap_ev = 1'b1;
        end
        if (cap_ev && !q.hold[i]) begin
          next_q.chv[i] = q.cnt;
          next_q.chf[i] = 1'b1;
          next_q.chf_armed[i] = 1'b0;
        end
      end else begin
        next_q.pin_oe[i] = 1'b1;
        cmp = tick && q.cnt == cmp_val && !hold_now;
        if (cmp) begin
          next_q.chf[i] = 1'b1;
          next_q.chf_armed[i] = 1'b0;
        end
        if (q.maxd_eff[i] && !q.tov[i]) begin
          next_q.pin_level[i] = (q.els[i] == ELS_CLEAR);
        end else if (ovf && q.tov[i]) begin
          next_q.pin_level[i] = !q.pin_level[i];
        end else if (cmp) begin
          unique case (q.els[i])
            ELS_TOGGLE: next_q.pin_level[i] = !q.pin_level[i];
            ELS_CLEAR: next_q.pin_level[i] = 1'b0;
            ELS_SET: next_q.pin_level[i] = 1'b1;
            default: next_q.pin_level[i] = q.pin_level[i];
          endcase
        end
      end
      cmp_ev[i] = cmp;
    end

    // Interrupt levels and pin direction force
    next_q.ovf_irq = next_q.overflow_flag && next_q.overflow_irq_enable;
    next_q.ch_irq = next_q.chf & next_q.chie;
    next_q.wake = next_q.ovf_irq || (|next_q.ch_irq);
    next_q.ext_in = next_q.ps == PS_EXTERNAL;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.stop <= STOP_RESET;
      q.modv <= MODULO_RESET;
      q.ps <= PS_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign ext_count_clock_input_o = q.ext_in;
  assign channel0_pin_o = q.pin_level[0];
  assign channel1_pin_o = q.pin_level[1];
  assign channel0_pin_oe_o = q.pin_oe[0];
  assign channel1_pin_oe_o = q.pin_oe[1];
  assign overflow_irq_o = q.ovf_irq;
  assign channel0_irq_o = q.ch_irq[0];
  assign channel1_irq_o = q.ch_irq[1];
  assign wakeup_o = q.wake;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  stop_holds_count_a: assert property (q.stop && !cnt_rst |=> $stable(q.cnt))
    else $error("counter moved while stopped");
  break_halts_count_a: assert property (break_i && !cnt_rst |=> $stable(q.cnt) && $stable(q.pre))
    else $error("counter moved during break");
  overflow_sets_flag_a: assert property (ovf && !q.mod_pend |=> q.overflow_flag ##1 overflow_irq_o == q.overflow_irq_enable)
    else $error("overflow flag or request wrong after rollover");
  wrap_to_zero_a: assert property (ovf |=> q.cnt == COUNT_ZERO)
    else $error("counter did not restart at zero");
  counter_reset_a: assert property (cnt_rst |=> q.cnt == COUNT_ZERO && q.pre == '0)
    else $error("counter reset did not clear counter and prescaler");
  stop_reset_zero_a: assert property (cnt_rst && wdata_i[SC_STOP_BIT] |=> q.stop && q.cnt == COUNT_ZERO ##1 q.cnt == COUNT_ZERO)
    else $error("counter left zero after stop with reset");
  break_flag_kept_a: assert property (break_i && !break_clear_enable_i && q.overflow_flag |=> q.overflow_flag)
    else $error("overflow flag cleared during protected break");
  modulo_pending_a: assert property (ovf && q.mod_pend |=> !$rose(q.overflow_flag))
    else $error("overflow flag moved while modulo update pending");
  full_duty_a: assert property (q.maxd_eff[0] && !q.tov[0] && !q.msb0 && q.msa[0] && q.els[0] == ELS_CLEAR
    && $stable(q.maxd_eff[0]) && $stable(q.els[0]) |=> channel0_pin_o)
    else $error("channel 0 not held at full duty");
  wait_blocks_a: assert property (wait_mode_i && rd_i |=> rdata_o == 8'h00)
    else $error("register read answered in wait mode");
  compare_flag_a: assert property (cmp_ev[0] |=> q.chf[0])
    else $error("channel 0 compare did not set its flag");

endmodule

// >>> bench/pin_side_model.sv
// Far-side pin model: external count clock, capture pin level, CAN frame pulse.
// Assumes the bench calls its tasks right after a rising edge of clk_i.
`timescale 1ns/10ps

module pin_side_model (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic ch0_o,
  output logic ch1_o,
  output logic can_pulse_o
);
  initial begin
    ext_clk_o = 1'b0;
    ch0_o = 1'b0;
    ch1_o = 1'b0;
    can_pulse_o = 1'b0;
  end

  // ==========================================================
  // Edges four bus cycles apart stay under half the bus rate
  task automatic ext_pulses(input int n);
    repeat (n) begin
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  // ==========================================================
  // Capture sources
  task automatic ch1_rise();
    ch1_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ch1_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic can_pulse();
    can_pulse_o <= 1'b1;
    @(posedge clk_i);
    can_pulse_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the timer core: registers, counting, flags, PWM, capture.
// Assumes the core and pin_side_model; the core carries its own assertions.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s expected %0h seen %0h", n, e, g); end end

module tb_top import timer_b_pkg::*; ;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wait_mode = 1'b0;
  logic brk = 1'b0;
  logic break_clear_enable = 1'b0;
  logic link = 1'b0;
  logic [7:0] rdata;
  logic ext_in, ch0_out, ch0_oe, ch1_out, ch1_oe, ovf_irq, ch0_irq, ch1_irq, wakeup;
  logic p_ext, p_ch0, p_ch1, p_can;
  int checked = 0;
  int fail_count = 0;

  always #12.5 clk = ~clk;

  timer_b_counter_pwm_core timer_b_counter_pwm_core_i (.clk_i(clk), .resetn_i(resetn), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .wait_mode_i(wait_mode), .break_i(brk),
    .break_clear_enable_i(break_clear_enable), .ext_count_clock_pin_i(p_ext), .ext_count_clock_input_o(ext_in),
    .channel0_pin_i(ch0_oe ? ch0_out : p_ch0), .channel1_pin_i(ch1_oe ? ch1_out : p_ch1),
    .can_frame_capture_pulse_i(p_can), .capture_link_enable_i(link), .channel0_pin_o(ch0_out),
    .channel0_pin_oe_o(ch0_oe), .channel1_pin_o(ch1_out), .channel1_pin_oe_o(ch1_oe),
    .overflow_irq_o(ovf_irq), .channel0_irq_o(ch0_irq), .channel1_irq_o(ch1_irq), .wakeup_o(wakeup));

  pin_side_model pin_side_model_i (.clk_i(clk), .ext_clk_o(p_ext), .ch0_o(p_ch0), .ch1_o(p_ch1),
    .can_pulse_o(p_can));

  // ==========================================================
  // Register port tasks
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    `CHK(n, e, v)
    @(posedge clk);
  endtask

  // Counts exactly n ticks at divide-by-one: stop clears at e0, sets at e0+n
  task automatic run_for(input logic [7:0] ctl, input int n);
    wr_reg(STATUS_CONTROL_ADDR, ctl);
    repeat (n - 2) @(posedge clk);
    wr_reg(STATUS_CONTROL_ADDR, ctl | 8'h20);
  endtask

  task automatic duty(input int e, input string n);
    int c;
    c = 0;
    repeat (12) begin
      @(negedge clk);
      c += (ch0_out === 1'b1) ? 1 : ((ch0_out === 1'b0) ? 0 : 100);
    end
    `CHK(n, e, c)
    @(posedge clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic fin(input string n);
    $display("test %s done", n);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(STATUS_CONTROL_ADDR, 8'h20, "sc_reset");
    rd_chk(COUNTER_HIGH_ADDR, 8'h00, "cnt_hi_reset");
    rd_chk(MODULO_HIGH_ADDR, 8'hFF, "mod_hi_reset");
    rd_chk(MODULO_LOW_ADDR, 8'hFF, "mod_lo_reset");
    rd_chk(8'h50, 8'h00, "unmapped");
    repeat (10) @(posedge clk);
    rd_chk(COUNTER_LOW_ADDR, 8'h00, "stopped");
    fin("reset");
    for (int k = 0; k < 7; k++) begin
      wr_reg(STATUS_CONTROL_ADDR, 8'h30 | 8'(k));
      run_for(8'(k), (k == 0) ? 8 : (8 << k) + (1 << (k - 1)));
      rd_chk(COUNTER_LOW_ADDR, 8'h08, "prescaled");
      rd_chk(STATUS_CONTROL_ADDR, 8'h20 | 8'(k), "ps_field");
    end
    fin("prescaler");
    rd_chk(COUNTER_HIGH_ADDR, 8'h00, "latch_hi");
    run_for(8'h00, 20);
    rd_chk(COUNTER_HIGH_ADDR, 8'h00, "latch_hi2");
    rd_chk(COUNTER_LOW_ADDR, 8'h08, "latched_lo");
    rd_chk(COUNTER_LOW_ADDR, 8'h1C, "live_lo");
    wr_reg(STATUS_CONTROL_ADDR, 8'h30);
    rd_chk(COUNTER_LOW_ADDR, 8'h00, "cnt_cleared");
    rd_chk(MODULO_LOW_ADDR, 8'hFF, "mod_kept");
    fin("latch");
    wr_reg(MODULO_HIGH_ADDR, 8'h00);
    wr_reg(MODULO_LOW_ADDR, 8'h05);
    run_for(8'h00, 6);
    rd_chk(STATUS_CONTROL_ADDR, 8'hA0, "ovf_flag");
    rd_chk(COUNTER_LOW_ADDR, 8'h00, "wrapped");
    `CHK("ovf_irq_off", 1'b0, ovf_irq)
    wr_reg(STATUS_CONTROL_ADDR, 8'hE0);
    settle(2);
    `CHK("ovf_irq_on", 1'b1, ovf_irq)
    `CHK("wakeup", 1'b1, wakeup)
    @(posedge clk);
    rd_chk(STATUS_CONTROL_ADDR, 8'hE0, "one_no_effect");
    wr_reg(STATUS_CONTROL_ADDR, 8'h60);
    rd_chk(STATUS_CONTROL_ADDR, 8'h60, "ovf_cleared");
    `CHK("ovf_irq_clr", 1'b0, ovf_irq)
    wr_reg(STATUS_CONTROL_ADDR, 8'h70);
    wr_reg(MODULO_HIGH_ADDR, 8'h00);
    run_for(8'h40, 6);
    rd_chk(STATUS_CONTROL_ADDR, 8'h60, "ovf_blocked");
    wr_reg(MODULO_LOW_ADDR, 8'h05);
    run_for(8'h40, 6);
    rd_chk(STATUS_CONTROL_ADDR, 8'hE0, "ovf_again");
    fin("overflow");
    brk <= 1'b1;
    wr_reg(STATUS_CONTROL_ADDR, 8'h60);
    rd_chk(STATUS_CONTROL_ADDR, 8'hE0, "brk_protect");
    run_for(8'h40, 10);
    rd_chk(COUNTER_HIGH_ADDR, 8'h00, "brk_halt");
    brk <= 1'b0;
    wr_reg(STATUS_CONTROL_ADDR, 8'h60);
    rd_chk(STATUS_CONTROL_ADDR, 8'h60, "second_step");
    run_for(8'h40, 3);
    rd_chk(COUNTER_LOW_ADDR, 8'h00, "brk_latch");
    rd_chk(COUNTER_LOW_ADDR, 8'h03, "resumed");
    run_for(8'h40, 3);
    brk <= 1'b1;
    break_clear_enable <= 1'b1;
    rd_chk(STATUS_CONTROL_ADDR, 8'hE0, "brk_flag");
    wr_reg(STATUS_CONTROL_ADDR, 8'h60);
    brk <= 1'b0;
    break_clear_enable <= 1'b0;
    rd_chk(STATUS_CONTROL_ADDR, 8'h60, "brk_cleared");
    wait_mode <= 1'b1;
    wr_reg(STATUS_CONTROL_ADDR, 8'h00);
    rd_chk(STATUS_CONTROL_ADDR, 8'h00, "wait_read");
    wait_mode <= 1'b0;
    rd_chk(STATUS_CONTROL_ADDR, 8'h60, "wait_write");
    fin("break_wait");
    wr_reg(STATUS_CONTROL_ADDR, 8'h30);
    wr_reg(CH0_CONTROL_ADDR + CH_HIGH_OFS, 8'h00);
    wr_reg(CH0_CONTROL_ADDR + CH_LOW_OFS, 8'h02);
    wr_reg(CH0_CONTROL_ADDR, 8'h5A);
    wr_reg(STATUS_CONTROL_ADDR, 8'h00);
    repeat (14) @(posedge clk);
    duty(6, "duty_tov");
    `CHK("ch0_irq", 1'b1, ch0_irq)
    `CHK("ch0_oe", 1'b1, ch0_oe)
    wr_reg(CH0_CONTROL_ADDR, 8'h18);
    repeat (8) @(posedge clk);
    duty(0, "duty_zero");
    wr_reg(CH0_CONTROL_ADDR, 8'h19);
    repeat (8) @(posedge clk);
    duty(12, "duty_full");
    wr_reg(STATUS_CONTROL_ADDR, 8'h30);
    wr_reg(CH0_CONTROL_ADDR, 8'h3A);
    wr_reg(CH0_CONTROL_ADDR + CH_STRIDE + CH_HIGH_OFS, 8'h00);
    wr_reg(CH0_CONTROL_ADDR + CH_STRIDE + CH_LOW_OFS, 8'h04);
    wr_reg(STATUS_CONTROL_ADDR, 8'h00);
    repeat (14) @(posedge clk);
    duty(10, "duty_buffered");
    `CHK("ch1_oe", 1'b0, ch1_oe)
    `CHK("ch1_pin", 1'b1, ch1_out)
    wr_reg(STATUS_CONTROL_ADDR, 8'h20);
    fin("pwm");
    rd_chk(CH0_CONTROL_ADDR, 8'hBA, "cmp_flag");
    wr_reg(CH0_CONTROL_ADDR, 8'h04);
    rd_chk(CH0_CONTROL_ADDR, 8'h04, "ch_flag_clr");
    pin_side_model_i.can_pulse();
    rd_chk(CH0_CONTROL_ADDR, 8'h04, "can_gated");
    link <= 1'b1;
    pin_side_model_i.can_pulse();
    rd_chk(CH0_CONTROL_ADDR, 8'h84, "can_capture");
    wr_reg(CH0_CONTROL_ADDR + CH_STRIDE, 8'h44);
    pin_side_model_i.ch1_rise();
    rd_chk(CH0_CONTROL_ADDR + CH_STRIDE, 8'hC4, "ch1_capture");
    `CHK("ch1_irq", 1'b1, ch1_irq)
    fin("capture");
    wr_reg(STATUS_CONTROL_ADDR, 8'h37);
    settle(2);
    `CHK("ext_input", 1'b1, ext_in)
    @(posedge clk);
    wr_reg(STATUS_CONTROL_ADDR, 8'h07);
    pin_side_model_i.ext_pulses(5);
    repeat (6) @(posedge clk);
    wr_reg(STATUS_CONTROL_ADDR, 8'h27);
    rd_chk(COUNTER_LOW_ADDR, 8'h05, "ext_count");
    wr_reg(STATUS_CONTROL_ADDR, 8'h20);
    settle(2);
    `CHK("ext_released", 1'b0, ext_in)
    fin("ext_clock");
    report_and_stop();
  end
endmodule
